// [osc_tick_sync.sv]
// Brings the watchdog oscillator into the core clock and marks its rising edges.
`timescale 1ns/1ns
module osc_tick_sync
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic osc_level,
	output logic      osc_tick
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic tick;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	// The first stage feeds only the second; edges are seen on later stages.
	always_comb
	begin
		s_nxt      = s_r;
		s_nxt.meta = osc_level;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
		s_nxt.tick = s_r.sync & ~s_r.prev;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign osc_tick = s_r.tick;

endmodule

// [tb_watchdog_timer_control.sv]
// Testbench for the watchdog timer control block.
`timescale 1ns/1ns
module tb_watchdog_timer_control;
	import wdt_pkg::*;
	logic       core_clk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic       osc_level = 1'h0, dog_restart = 1'h0, irq_vector_taken = 1'h0;
	logic       global_irq_enable = 1'h1, always_on_fuse = 1'h1;
	logic       dog_reset_cause_flag = 1'h0, timeout_irq_req, sys_reset_req;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, b;
	int         fail_count = 0, n_tests = 0, cyc = 0, i, c;
	watchdog_timer_control dut (.core_clk, .reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .osc_level, .dog_restart,
		.irq_vector_taken, .global_irq_enable, .always_on_fuse,
		.dog_reset_cause_flag, .timeout_irq_req, .sys_reset_req);
	always #10 core_clk = ~core_clk;
	initial
	begin
		#3;
		forever #80 osc_level = ~osc_level;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'h1};
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'h1};
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask
	task automatic pulse(input logic v);
		@(posedge core_clk);
		{irq_vector_taken, dog_restart} <= {v, !v};
		@(posedge core_clk);
		{irq_vector_taken, dog_restart} <= 2'h0;
	endtask
	task automatic wt(input logic r, input int n);
		i = 0;
		while ((r ? sys_reset_req : timeout_irq_req) !== 1'h1 && i < 9000)
		begin
			@(posedge core_clk);
			#1;
			i++;
		end
		chk("time", {7'h0, i >= n * 8 - 20 && i <= n * 8 + 6}, 8'h01);
	endtask
	function automatic int per(input int k);
		return k > 13 ? 128 : 1024 >> (k - 10);
	endfunction
	function automatic logic [7:0] enc(input logic ie, we, input int k);
		return {1'h0, ie, k[3], 1'h0, we, k[2:0]};
	endfunction
	initial
	begin
		void'($urandom(95));
		repeat (6) @(posedge core_clk);
		reset_n <= 1'h1;
		rd(8'h00);
		chk("reset", d, 8'h00);
		for (c = 10; c < 15; c++)
		begin
			b = enc(1'h1, 1'h0, c);
			pulse(1'h0);
			wr(8'h00, b | 8'h18);
			wr(8'h00, b);
			pulse(1'h0);
			wt(1'h0, per(c));
			rd(8'h00);
			chk("flag", d, b | 8'h80);
			@(posedge core_clk);
			global_irq_enable <= 1'($urandom);
			repeat (2) @(posedge core_clk);
			#1;
			chk("req", {7'h0, timeout_irq_req}, {7'h0, global_irq_enable});
			rd(8'h01 + 8'($urandom % 255));
			chk("unmapped", d, 8'h00);
			if (c[0])
				pulse(1'h1);
			else
				wr(8'h00, b | 8'h80);
			rd(8'h00);
			chk("clear", d, b);
			@(posedge core_clk);
			global_irq_enable <= 1'h1;
			$display("period test done");
		end
		b = enc(1'h1, 1'h1, 13);
		wr(8'h00, b | 8'h10);
		wr(8'h00, b);
		pulse(1'h0);
		wt(1'h0, 128);
		pulse(1'h1);
		rd(8'h00);
		chk("vector", d, 8'h2D);
		wt(1'h1, 128);
		wr(8'h00, b);
		pulse(1'h0);
		wt(1'h0, 128);
		wt(1'h1, 128);
		wr(8'h00, 8'hAD);
		$display("combined test done");
		always_on_fuse <= 1'h0;
		rd(8'h00);
		chk("fuse", d & 8'h48, 8'h08);
		@(posedge core_clk);
		always_on_fuse <= 1'h1;
		wr(8'h00, 8'h3D);
		repeat (6) @(posedge core_clk);
		wr(8'h00, 8'h00);
		rd(8'h00);
		chk("late", d, 8'h2D);
		wr(8'h00, 8'h3D);
		rd(8'h00);
		chk("window", d, 8'h3D);
		wr(8'h00, 8'h00);
		rd(8'h00);
		chk("off", d, 8'h00);
		@(posedge core_clk);
		dog_reset_cause_flag <= 1'h1;
		rd(8'h00);
		chk("cause", d, 8'h08);
		$display("register test done");
		test_done();
	end
endmodule

// [watchdog_timer_control.sv]
// Watchdog timer with its control and status register.
//
// What this block and its software do
// (R1) Time-out in an interrupt mode sets the flag in bit 7.
// (R2) Executing the watchdog vector clears the flag in hardware.
// (R3) Writing one to the flag clears it; zero leaves it.
// (R4) Interrupt requested only with global enable, bit 6 enable and flag set.
// (R5) Reset enable clear, interrupt enable set: interrupt on every time-out.
// (R6) Fuse unprogrammed: 00 stop, 01 irq, 10 reset, 11 irq then reset.
// (R7) In combined mode the vector clears interrupt enable and flag.
// (R8) Combined mode: time-out with flag still pending applies system reset.
// (R9) Software re-enables the interrupt after each one, outside the handler.
// (R10) Programmed fuse (0) forces reset mode whatever the enable bits.
// (R11) Clearing reset enable or changing period needs change window bit 4.
// (R12) Change window bit clears itself four core cycles after set.
// (R13) Reset enable reads and acts set while the reset cause flag is set.
// (R14) Period codes 0000 to 1001 double from 2048 to 1048576 cycles.
// (R15) Codes 1010 to 1101 give 1024, 512, 256, 128; 1110, 1111 reserved.
// (R16) Software restarts the counter before changing the period.
// (R17) Software opens the window then writes new values within four cycles.
// (R18) The counter counts cycles of the separate 128 kHz oscillator.
// (R19) The restart input clears the counter; software restarts in time.
// (R20) Programmed fuse locks reset enable at 1 and interrupt enable at 0.
// (R21) Oscillator edges are synchronised into the core clock first.
// (R22) Reserved period codes are stored and count the 128 cycle period.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module watchdog_timer_control
	import wdt_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       osc_level,
	input  wire logic       dog_restart,
	input  wire logic       irq_vector_taken,
	input  wire logic       global_irq_enable,
	input  wire logic       always_on_fuse,
	input  wire logic       dog_reset_cause_flag,
	output logic            timeout_irq_req,
	output logic            sys_reset_req
);

	import wdt_pkg::*;

	typedef struct packed {
		logic                 timeout_irq_flag;
		logic                 timeout_irq_enable;
		logic                 sys_reset_enable;
		logic [3:0]           period_select;
		logic [2:0]           window_count;
		logic [COUNT_W-1:0]   count;
		logic [7:0]           rdata;
		logic                 irq_req;
		logic                 reset_req;
	} dog_state_t;

	dog_state_t s_r;
	dog_state_t s_nxt;

	logic              osc_tick;
	logic              fuse_programmed;
	logic              reset_en_eff;
	logic              irq_en_eff;
	logic              window_open;
	dog_mode_t         mode;
	logic [COUNT_W-1:0] limit;
	logic              timeout;
	logic              sel;
	logic              wr_hit;
	logic              set_flag;
	logic [7:0]        read_value;
	logic [3:0]        new_period;

	osc_tick_sync u_sync
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.osc_level (osc_level),
		.osc_tick  (osc_tick)     // [R21] [R18]
	);

	always_comb
	begin
		fuse_programmed = ~always_on_fuse;                          // [R10]
		// Fuse and the reset cause flag both hold reset enable high.
		reset_en_eff = s_r.sys_reset_enable | dog_reset_cause_flag
			| fuse_programmed;                                        // [R13] [R20]
		irq_en_eff = s_r.timeout_irq_enable & ~fuse_programmed;     // [R20]
		window_open = (s_r.window_count != 3'h0);
		case ({reset_en_eff, irq_en_eff})                           // [R6]
			2'b00:   mode = MODE_STOPPED;
			2'b01:   mode = MODE_IRQ;                               // [R5]
			2'b10:   mode = MODE_RESET;                             // [R10]
			2'b11:   mode = MODE_IRQ_RESET;
			default: mode = MODE_STOPPED;
		endcase
		limit = period_cycles(s_r.period_select);                   // [R14] [R15] [R22]
		timeout = osc_tick && (mode != MODE_STOPPED) && !dog_restart
			&& (s_r.count == limit - 21'h000001);
		sel = (reg_addr == CTRL_STATUS_OFFSET);
		wr_hit = reg_wr & sel;
		read_value = 8'h00;
		read_value[IRQ_FLAG_BIT] = s_r.timeout_irq_flag;
		read_value[IRQ_ENABLE_BIT] = irq_en_eff;
		read_value[PERIOD_HI_BIT] = s_r.period_select[3];
		read_value[CHANGE_WINDOW_BIT] = window_open;
		read_value[RESET_ENABLE_BIT] = reset_en_eff;                // [R13]
		read_value[PERIOD_LO_TOP:0] = s_r.period_select[2:0];
		new_period = {reg_wdata[PERIOD_HI_BIT],
			reg_wdata[PERIOD_LO_TOP:0]};
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.reset_req = 1'b0;
		set_flag = 1'b0;

		// Counter runs on oscillator rising edges while the dog is not stopped.
		if (dog_restart || mode == MODE_STOPPED)
		begin
			s_nxt.count = '0;                                         // [R19]
		end
		else if (timeout)
		begin
			s_nxt.count = '0;
		end
		else if (osc_tick)
		begin
			s_nxt.count = s_r.count + 21'h000001;                     // [R18]
		end

		if (timeout)
		begin
			case (mode)
				MODE_IRQ:
				begin
					set_flag = 1'b1;                                  // [R1] [R5]
				end
				MODE_RESET:
				begin
					s_nxt.reset_req = 1'b1;                           // [R10]
				end
				MODE_IRQ_RESET:
				begin
					if (s_r.timeout_irq_flag)
					begin
						s_nxt.reset_req = 1'b1;                       // [R8]
					end
					else
					begin
						set_flag = 1'b1;                              // [R1]
					end
				end
				default:
				begin
					set_flag = 1'b0;
				end
			endcase
		end

		if (s_r.window_count != 3'h0)
		begin
			s_nxt.window_count = s_r.window_count - 3'h1;             // [R12]
		end

		if (wr_hit)
		begin
			if (reg_wdata[IRQ_FLAG_BIT])
			begin
				s_nxt.timeout_irq_flag = 1'b0;                        // [R3]
			end
			s_nxt.timeout_irq_enable = reg_wdata[IRQ_ENABLE_BIT];
			if (reg_wdata[RESET_ENABLE_BIT])
			begin
				s_nxt.sys_reset_enable = 1'b1;
			end
			else if (window_open)
			begin
				s_nxt.sys_reset_enable = 1'b0;                        // [R11]
			end
			if (window_open)
			begin
				s_nxt.period_select = new_period;                     // [R11] [R22]
			end
			if (reg_wdata[CHANGE_WINDOW_BIT])
			begin
				s_nxt.window_count = CHANGE_WINDOW_CYCLES;            // [R12]
			end
		end

		if (irq_vector_taken)
		begin
			s_nxt.timeout_irq_flag = 1'b0;                            // [R2]
			if (mode == MODE_IRQ_RESET)
			begin
				s_nxt.timeout_irq_enable = 1'b0;                      // [R7]
			end
		end

		// A time-out in the same cycle as a clear keeps the flag set.
		if (set_flag)
		begin
			s_nxt.timeout_irq_flag = 1'b1;                            // [R1]
		end

		s_nxt.irq_req = s_nxt.timeout_irq_flag & global_irq_enable
			& s_nxt.timeout_irq_enable & ~fuse_programmed;            // [R4]

		if (reg_rd && sel)
		begin
			s_nxt.rdata = read_value;
		end
		else
		begin
			s_nxt.rdata = 8'h00;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_r <= '0;
			s_r.timeout_irq_flag <= IRQ_FLAG_RESET;
			s_r.timeout_irq_enable <= IRQ_ENABLE_RESET;
			s_r.sys_reset_enable <= RESET_ENABLE_RESET;
			s_r.period_select <= PERIOD_RESET;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign timeout_irq_req = s_r.irq_req;
	assign sys_reset_req = s_r.reset_req;

endmodule

// [wdt_chk.sv]
// Checker for the watchdog register port and its request outputs.
`timescale 1ns/1ns
module wdt_chk
(
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       global_irq_enable,
	input wire logic       always_on_fuse,
	input wire logic       dog_reset_cause_flag,
	input wire logic       timeout_irq_req,
	input wire logic       sys_reset_req
);
	logic [2:0] win_r;
	logic       rd0;
	assign rd0 = reg_rd && reg_addr == 8'h00;
	always_ff @(posedge core_clk or negedge reset_n)
		if (!reset_n)
			win_r <= 3'h7;
		else if (reg_wr && reg_addr == 8'h00 && reg_wdata[4])
			win_r <= 3'h0;
		else if (win_r != 3'h7)
			win_r <= win_r + 3'h1;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_rdata_unmapped: assert property ($past(reg_rd && reg_addr != 8'h00)
		|-> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_irq_gate: assert property (timeout_irq_req
		|-> $past(global_irq_enable && always_on_fuse)) else $error("irq gate");
	a_irq_flag: assert property (rd0 && timeout_irq_req
		|=> reg_rdata[7:6] == 2'h3) else $error("irq without flag");
	a_fuse_lock: assert property (rd0 && !always_on_fuse
		|=> {reg_rdata[6], reg_rdata[3]} == 2'h1) else $error("fuse lock");
	a_cause_set: assert property (rd0 && dog_reset_cause_flag
		|=> reg_rdata[3]) else $error("cause flag not forcing");
	a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
		else $error("reset request too long");
	a_window_close: assert property (reg_rdata[4] |-> win_r <= 3'h4)
		else $error("window open too long");
	cover property ($rose(timeout_irq_req));
	cover property (sys_reset_req);
	cover property (reg_rdata[4]);
endmodule
bind watchdog_timer_control wdt_chk u_chk (.core_clk, .reset_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_irq_enable,
	.always_on_fuse, .dog_reset_cause_flag, .timeout_irq_req, .sys_reset_req);

// [wdt_pkg.sv]
// Package with the register map, field positions and timing constants.
package wdt_pkg;

	localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h00;

	localparam int IRQ_FLAG_BIT      = 7;
	localparam int IRQ_ENABLE_BIT    = 6;
	localparam int PERIOD_HI_BIT     = 5;
	localparam int CHANGE_WINDOW_BIT = 4;
	localparam int RESET_ENABLE_BIT  = 3;
	localparam int PERIOD_LO_TOP     = 2;

	localparam logic       IRQ_FLAG_RESET     = 1'b0;
	localparam logic       IRQ_ENABLE_RESET   = 1'b0;
	localparam logic       RESET_ENABLE_RESET = 1'b0;
	localparam logic [3:0] PERIOD_RESET       = 4'h0;

	localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;

	localparam int            COUNT_W         = 21;
	localparam logic [3:0]    LONG_CODE_LAST  = 4'h9;
	localparam logic [3:0]    SHORT_CODE_LAST = 4'hD;
	localparam logic [3:0]    SHORT_CODE_BASE = 4'hA;
	localparam logic [20:0]   LONG_BASE       = 21'h000800;
	localparam logic [20:0]   SHORT_BASE      = 21'h000400;
	localparam logic [20:0]   SHORTEST_PERIOD = 21'h000080;

	typedef enum logic [1:0] {
		MODE_STOPPED,
		MODE_IRQ,
		MODE_RESET,
		MODE_IRQ_RESET
	} dog_mode_t;

	function automatic logic [20:0] period_cycles(input logic [3:0] code);
		logic [3:0] shift;
		shift = 4'h0;
		if (code <= LONG_CODE_LAST)
		begin
			period_cycles = LONG_BASE << code;
		end
		else if (code <= SHORT_CODE_LAST)
		begin
			shift = code - SHORT_CODE_BASE;
			period_cycles = SHORT_BASE >> shift;
		end
		else
		begin
			period_cycles = SHORTEST_PERIOD;
		end
	endfunction

endpackage
